// ===== src/dsu_consts.svh
`ifndef DSU_CONSTS_SVH
`define DSU_CONSTS_SVH

// serial word layout
`define DSU_WORD_W        24
`define DSU_WORD_LAST     5'h17
`define DSU_CNT_W         5
`define DSU_CMD_MSB       19
`define DSU_CMD_LSB       16
`define DSU_CMD_W         4
`define DSU_DATA_W        16
`define DSU_DATA_MSB      15
`define DSU_RB_PAD        4'h0

// command codes
`define DSU_CMD_NOP       4'h0
`define DSU_CMD_WR_INPUT  4'h1
`define DSU_CMD_UPD_DAC   4'h2
`define DSU_CMD_WR_CTRL   4'h4
`define DSU_CMD_RD_INPUT  4'hA
`define DSU_CMD_RD_DAC    4'hB
`define DSU_CMD_RD_CTRL   4'hC
`define DSU_CMD_SW_RESET  4'hF

// control register
`define DSU_CTRL_W        8
`define DSU_CTRL_MSB      7
`define DSU_CTRL_RST      8'h00
`define DSU_CLR_SEL_MSB   1
`define DSU_CLR_SEL_LSB   0
`define DSU_OUT_EN_BIT    2

// clear presets
`define DSU_CLR_ZERO      2'h0
`define DSU_CLR_MID       2'h1
`define DSU_CLR_FULL      2'h2
`define DSU_CODE_ZERO     16'h0000
`define DSU_CODE_MID      16'h8000
`define DSU_CODE_FULL     16'hFFFF

// reset values
`define DSU_INPUT_RST     16'h0000
`define DSU_DAC_RST       16'h0000
`define DSU_WORD_RST      24'h000000

// pin synchroniser lanes
`define DSU_PIN_W         7
`define DSU_PIN_SYNC      0
`define DSU_PIN_LOAD      1
`define DSU_PIN_CLEAR     2
`define DSU_PIN_HWRST     3
`define DSU_PIN_OTEMP     4
`define DSU_PIN_SHORT     5
`define DSU_PIN_BROWN     6
`define DSU_PIN_IDLE      7'h0F

`endif

// ===== src/dsu_pkg.sv
package dsu_pkg;
   typedef enum logic [1:0] {
      DSU_ST_IDLE  = 2'b01,
      DSU_ST_DEFER = 2'b10
   } dsu_state_t;
endpackage

// ===== src/dsu_sync.sv
`timescale 1ns/1ps
`include "dsu_consts.svh"
module dsu_sync (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  wire logic                  i_ce,
   input  wire logic [`DSU_PIN_W-1:0] i_async,
   output logic      [`DSU_PIN_W-1:0] o_sync
);
   import dsu_pkg::*;

   logic [`DSU_PIN_W-1:0] meta;
   logic [`DSU_PIN_W-1:0] next_meta;
   logic [`DSU_PIN_W-1:0] next_sync;

   always_comb begin
      next_meta = i_ce ? i_async : meta;
      next_sync = i_ce ? meta : o_sync;
   end

   // idle pattern keeps strobes high so no false edge after reset
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         meta   <= `DSU_PIN_IDLE;
         o_sync <= `DSU_PIN_IDLE;
      end else begin
         meta   <= next_meta;
         o_sync <= next_sync;
      end
   end
endmodule

// ===== src/dsu_link.sv
`timescale 1ns/1ps
`include "dsu_consts.svh"
module dsu_link (
   input  wire logic                   i_sclk,
   input  wire logic                   i_rst,
   input  wire logic                   i_sync_n,
   input  wire logic                   i_serial_data_in,
   input  wire logic                   i_rb_armed,
   input  wire logic [`DSU_WORD_W-1:0] i_rb_word,
   output logic      [`DSU_WORD_W-1:0] o_shift_word,
   output logic                        o_serial_data_out
);
   import dsu_pkg::*;

   logic [`DSU_CNT_W-1:0]  cnt;
   logic [`DSU_CNT_W-1:0]  next_cnt;
   logic [`DSU_WORD_W-1:0] next_shift;
   logic                   next_sdo;
   logic                   frame_rst;
   logic [`DSU_CNT_W-1:0]  rb_idx;

   // the frame's own strobe ends the bit count; sclk may stop between frames
   assign frame_rst = i_rst | i_sync_n;

   always_comb begin
      next_shift = o_shift_word;
      next_cnt   = cnt;
      if (!i_sync_n) begin
         next_shift = {o_shift_word[`DSU_WORD_W-2:0], i_serial_data_in};
         if (cnt != `DSU_WORD_LAST) begin
            next_cnt = cnt + 5'h01;
         end
      end
   end

   always_ff @(negedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         o_shift_word <= `DSU_WORD_RST;
      end else begin
         o_shift_word <= next_shift;
      end
   end

   always_ff @(negedge i_sclk or posedge frame_rst) begin
      if (frame_rst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // readback word is static while a frame runs, barring a hardware reset; the
   // system side otherwise only changes it after the frame has closed
   always_comb begin
      rb_idx   = `DSU_WORD_LAST - cnt;
      next_sdo = o_serial_data_out;
      if (!i_sync_n) begin
         next_sdo = i_rb_armed ? i_rb_word[rb_idx] : o_shift_word[`DSU_WORD_W-1];
      end
   end

   always_ff @(posedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         o_serial_data_out <= 1'b0;
      end else begin
         o_serial_data_out <= next_sdo;
      end
   end
endmodule

// ===== src/dsu_update_ctrl.sv
// Contract
// - data out changes rising, valid falling edge
// - load low: converter follows input write
// - load high: update deferred to load fall
// - frame while strobe low, shift on fall
// - word acted on at strobe rising edge
// - fault low on heat, short, brownout
// - fault held after reset until control write
// - clear fall loads preset code at once
// - hardware reset restores all defaults but shift word and data out
`timescale 1ns/1ps
`include "dsu_consts.svh"
module dsu_update_ctrl (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rst,
   input  wire logic                   i_ce,
   input  wire logic                   i_sclk,
   input  wire logic                   i_sync_n,
   input  wire logic                   i_serial_data_in,
   input  wire logic                   i_load_strobe_n,
   input  wire logic                   i_clear_n,
   input  wire logic                   i_hw_reset_n,
   input  wire logic                   i_overtemp,
   input  wire logic                   i_short_circuit,
   input  wire logic                   i_brownout,
   output logic                        o_serial_data_out,
   output logic [`DSU_DATA_W-1:0]      o_dac_code,
   output logic                        o_out_clamp,
   output logic                        o_buf_powerdown,
   output logic                        o_fault_n,
   output dsu_pkg::dsu_state_t         o_update_state
);
   import dsu_pkg::*;

   logic [`DSU_PIN_W-1:0]  pins_s;
   logic [`DSU_WORD_W-1:0] shift_word;
   logic                   sync_s;
   logic                   load_s;
   logic                   clear_s;
   logic                   hwrst_s;
   logic                   fault_any;

   logic                   sync_d;
   logic                   load_d;
   logic                   clear_d;
   logic [`DSU_DATA_W-1:0] input_reg;
   logic [`DSU_CTRL_W-1:0] ctrl_reg;
   logic [`DSU_WORD_W-1:0] rb_word;
   logic                   rb_armed;
   logic                   alert_hold;

   logic                   next_sync_d;
   logic                   next_load_d;
   logic                   next_clear_d;
   logic [`DSU_DATA_W-1:0] next_input_reg;
   logic [`DSU_DATA_W-1:0] next_dac_code;
   logic [`DSU_CTRL_W-1:0] next_ctrl_reg;
   logic [`DSU_WORD_W-1:0] next_rb_word;
   logic                   next_rb_armed;
   logic                   next_alert_hold;
   logic                   next_out_clamp;
   logic                   next_buf_powerdown;
   logic                   next_fault_n;
   dsu_state_t             next_state;

   logic                   frame_end;
   logic                   load_fall;
   logic                   clear_fall;
   logic [`DSU_CMD_W-1:0]  cmd;
   logic [`DSU_DATA_W-1:0] data;

   function automatic logic [`DSU_DATA_W-1:0] dsu_preset(input logic [1:0] sel);
      case (sel)
         `DSU_CLR_ZERO: dsu_preset = `DSU_CODE_ZERO;
         `DSU_CLR_MID:  dsu_preset = `DSU_CODE_MID;
         `DSU_CLR_FULL: dsu_preset = `DSU_CODE_FULL;
         default:       dsu_preset = `DSU_CODE_ZERO;
      endcase
   endfunction

   function automatic logic dsu_is_readback(input logic [`DSU_CMD_W-1:0] c);
      dsu_is_readback = (c == `DSU_CMD_RD_INPUT) || (c == `DSU_CMD_RD_DAC) || (c == `DSU_CMD_RD_CTRL);
   endfunction

   dsu_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_async   ({i_brownout, i_short_circuit, i_overtemp, i_hw_reset_n,
                   i_clear_n, i_load_strobe_n, i_sync_n}),
      .o_sync    (pins_s)
   );

   dsu_link u_link (
      .i_sclk            (i_sclk),
      .i_rst             (i_rst),
      .i_sync_n          (i_sync_n),
      .i_serial_data_in  (i_serial_data_in),
      .i_rb_armed        (rb_armed),
      .i_rb_word         (rb_word),
      .o_shift_word      (shift_word),
      .o_serial_data_out (o_serial_data_out)
   );

   assign sync_s    = pins_s[`DSU_PIN_SYNC];
   assign load_s    = pins_s[`DSU_PIN_LOAD];
   assign clear_s   = pins_s[`DSU_PIN_CLEAR];
   assign hwrst_s   = pins_s[`DSU_PIN_HWRST];
   assign fault_any = pins_s[`DSU_PIN_OTEMP] | pins_s[`DSU_PIN_SHORT] | pins_s[`DSU_PIN_BROWN];

   // the shift word is quiet once the strobe is high, and the strobe edge
   // reaches this domain two cycles late, so the word is safe to read here
   assign frame_end  = sync_s & ~sync_d;
   assign load_fall  = ~load_s & load_d;
   assign clear_fall = ~clear_s & clear_d;
   assign cmd        = shift_word[`DSU_CMD_MSB:`DSU_CMD_LSB];
   assign data       = shift_word[`DSU_DATA_MSB:0];

   always_comb begin
      next_sync_d        = sync_s;
      next_load_d        = load_s;
      next_clear_d       = clear_s;
      next_input_reg     = input_reg;
      next_dac_code      = o_dac_code;
      next_ctrl_reg      = ctrl_reg;
      next_rb_word       = rb_word;
      next_rb_armed      = rb_armed;
      next_alert_hold    = alert_hold;
      next_out_clamp     = o_out_clamp;
      next_buf_powerdown = o_buf_powerdown;
      next_state         = o_update_state;

      case (o_update_state)
         DSU_ST_IDLE: begin
            if (load_fall) begin
               next_dac_code = input_reg;
            end
         end
         DSU_ST_DEFER: begin
            if (load_fall) begin
               next_dac_code = input_reg;
               next_state    = DSU_ST_IDLE;
            end
         end
         default: begin
            next_state = DSU_ST_IDLE;
         end
      endcase

      if (frame_end) begin
         // a readback word is shifted out in the frame after its request
         next_rb_armed = 1'b0;
         case (cmd)
            `DSU_CMD_WR_INPUT: begin
               next_input_reg = data;
               if (!load_s) begin
                  next_dac_code = data;
                  next_state    = DSU_ST_IDLE;
               end else begin
                  next_state    = DSU_ST_DEFER;
               end
            end
            `DSU_CMD_UPD_DAC: begin
               next_dac_code = input_reg;
               next_state    = DSU_ST_IDLE;
            end
            `DSU_CMD_WR_CTRL: begin
               next_ctrl_reg      = data[`DSU_CTRL_MSB:0];
               next_alert_hold    = 1'b0;
               next_out_clamp     = ~data[`DSU_OUT_EN_BIT];
               next_buf_powerdown = ~data[`DSU_OUT_EN_BIT];
            end
            `DSU_CMD_RD_INPUT: begin
               next_rb_word = {`DSU_RB_PAD, cmd, input_reg};
            end
            `DSU_CMD_RD_DAC: begin
               next_rb_word = {`DSU_RB_PAD, cmd, o_dac_code};
            end
            `DSU_CMD_RD_CTRL: begin
               next_rb_word = {`DSU_RB_PAD, cmd, {(`DSU_DATA_W-`DSU_CTRL_W){1'b0}}, ctrl_reg};
            end
            `DSU_CMD_SW_RESET: begin
               next_input_reg     = `DSU_INPUT_RST;
               next_dac_code      = `DSU_DAC_RST;
               next_ctrl_reg      = `DSU_CTRL_RST;
               next_alert_hold    = 1'b1;
               next_out_clamp     = 1'b1;
               next_buf_powerdown = 1'b1;
               next_state         = DSU_ST_IDLE;
            end
            default: begin
               next_rb_armed = 1'b0;
            end
         endcase
         if (dsu_is_readback(cmd)) begin
            next_rb_armed = 1'b1;
         end
      end

      // clear outranks a frame or load edge in the same cycle
      if (clear_fall) begin
         next_dac_code = dsu_preset(ctrl_reg[`DSU_CLR_SEL_MSB:`DSU_CLR_SEL_LSB]);
         next_state    = DSU_ST_IDLE;
      end

      if (!hwrst_s) begin
         next_input_reg     = `DSU_INPUT_RST;
         next_dac_code      = `DSU_DAC_RST;
         next_ctrl_reg      = `DSU_CTRL_RST;
         next_rb_word       = `DSU_WORD_RST;
         next_rb_armed      = 1'b0;
         next_alert_hold    = 1'b1;
         next_out_clamp     = 1'b1;
         next_buf_powerdown = 1'b1;
         next_state         = DSU_ST_IDLE;
      end

      next_fault_n = ~(fault_any | next_alert_hold);
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sync_d          <= 1'b1;
         load_d          <= 1'b1;
         clear_d         <= 1'b1;
         input_reg       <= `DSU_INPUT_RST;
         o_dac_code      <= `DSU_DAC_RST;
         ctrl_reg        <= `DSU_CTRL_RST;
         rb_word         <= `DSU_WORD_RST;
         rb_armed        <= 1'b0;
         alert_hold      <= 1'b1;
         o_out_clamp     <= 1'b1;
         o_buf_powerdown <= 1'b1;
         o_fault_n       <= 1'b0;
         o_update_state  <= DSU_ST_IDLE;
      end else if (i_ce) begin
         sync_d          <= next_sync_d;
         load_d          <= next_load_d;
         clear_d         <= next_clear_d;
         input_reg       <= next_input_reg;
         o_dac_code      <= next_dac_code;
         ctrl_reg        <= next_ctrl_reg;
         rb_word         <= next_rb_word;
         rb_armed        <= next_rb_armed;
         alert_hold      <= next_alert_hold;
         o_out_clamp     <= next_out_clamp;
         o_buf_powerdown <= next_buf_powerdown;
         o_fault_n       <= next_fault_n;
         o_update_state  <= next_state;
      end
   end
endmodule

// ===== sim/dsu_update_ctrl_sva.sv
`timescale 1ns/1ps
`include "dsu_consts.svh"
module dsu_update_ctrl_sva
   import dsu_pkg::*;
(
   input wire logic                   i_clk_sys,
   input wire logic                   i_rst,
   input wire logic                   i_ce,
   input wire logic                   i_sclk,
   input wire logic                   i_sync_n,
   input wire logic                   i_load_strobe_n,
   input wire logic                   i_clear_n,
   input wire logic                   i_hw_reset_n,
   input wire logic                   i_overtemp,
   input wire logic                   i_short_circuit,
   input wire logic                   i_brownout,
   input wire logic                   o_serial_data_out,
   input wire logic [`DSU_DATA_W-1:0] o_dac_code,
   input wire logic                   o_out_clamp,
   input wire logic                   o_buf_powerdown,
   input wire logic                   o_fault_n,
   input wire dsu_state_t             o_update_state
);
   wire any_fault = i_overtemp | i_short_circuit | i_brownout;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // a low enable freezes the synchronisers, so only enabled cycles count
   chk_fault_pin: assert property ((any_fault && i_ce) [*4] |-> !o_fault_n)
      else $error("fault flag not low under fault");
   // pins are synchronised, so the flag trails them by three enabled edges
   chk_fault_rise: assert property ($rose(o_fault_n) |-> !$past(any_fault, 3))
      else $error("fault flag released while fault present");
   chk_rst_dflt: assert property ($past(i_rst) |-> !o_fault_n && o_out_clamp && o_buf_powerdown)
      else $error("defaults missing after reset");
   chk_hw_dflt: assert property (!i_hw_reset_n [*4] |-> o_out_clamp && o_buf_powerdown && !o_fault_n
      && o_dac_code == `DSU_DAC_RST && o_update_state == DSU_ST_IDLE)
      else $error("hardware reset did not restore defaults");
   chk_clear_set: assert property ($fell(i_clear_n) |-> ##[2:4] o_update_state == DSU_ST_IDLE &&
      (o_dac_code == `DSU_CODE_ZERO || o_dac_code == `DSU_CODE_MID || o_dac_code == `DSU_CODE_FULL))
      else $error("clear did not load a preset");
   chk_defer_hold: assert property ($rose(o_update_state == DSU_ST_DEFER) |-> $stable(o_dac_code))
      else $error("converter changed on deferred write");
   chk_defer_load: assert property (o_update_state == DSU_ST_DEFER && $fell(i_load_strobe_n)
      |-> ##[2:4] o_update_state == DSU_ST_IDLE)
      else $error("deferred update not done on load fall");
   chk_frame_quiet: assert property ((!i_sync_n && i_load_strobe_n && i_clear_n && i_hw_reset_n) [*5]
      |-> $stable(o_dac_code))
      else $error("converter changed inside a frame");
   chk_sdo_edge: assert property ($changed(o_serial_data_out) |-> $rose(i_sclk))
      else $error("serial out changed off a rising edge");

   cover property ($rose(o_update_state == DSU_ST_DEFER));
   cover property ($fell(i_clear_n));
   cover property ($rose(o_fault_n));
endmodule

bind dsu_update_ctrl dsu_update_ctrl_sva dsu_update_ctrl_sva_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
   .i_sclk(i_sclk), .i_sync_n(i_sync_n), .i_load_strobe_n(i_load_strobe_n), .i_clear_n(i_clear_n),
   .i_hw_reset_n(i_hw_reset_n), .i_overtemp(i_overtemp), .i_short_circuit(i_short_circuit),
   .i_brownout(i_brownout), .o_serial_data_out(o_serial_data_out), .o_dac_code(o_dac_code),
   .o_out_clamp(o_out_clamp), .o_buf_powerdown(o_buf_powerdown), .o_fault_n(o_fault_n),
   .o_update_state(o_update_state));

// ===== sim/dsu_host_model.sv
`timescale 1ns/1ps
module dsu_host_model (
   input  wire logic i_sdo,
   output logic      o_sclk,
   output logic      o_sync_n,
   output logic      o_sdi
);
   initial begin
      o_sclk = 1'b0;
      o_sync_n = 1'b1;
      o_sdi = 1'b0;
   end
   // 48 ns period, well under the 50 MHz ceiling; sclk idles low so rise precedes fall
   task automatic xfer(input logic [23:0] w, output logic [23:0] rx);
      rx = 24'h000000;
      // step off the system edge and off a stray clock's last fall
      #1 o_sync_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         o_sdi = w[i];
         #12 o_sclk = 1'b1;
         #24 rx = {rx[22:0], i_sdo};
         o_sclk = 1'b0;
         #12;
      end
      o_sync_n = 1'b1;
      o_sdi = ~o_sdi;
      #40;
   endtask
   // stray clocks with the frame closed, only when a test asks for them
   task automatic idle_clocks(input int n);
      repeat (n) begin
         #24 o_sclk = 1'b1;
         o_sdi = ~o_sdi;
         #24 o_sclk = 1'b0;
      end
   endtask
endmodule

// ===== sim/dac_serial_update_control_tb_top.sv
`timescale 1ns/1ps
`include "dsu_consts.svh"
module dac_serial_update_control_tb_top;
   import dsu_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        load_n = 1'b0;
   logic        clear_n = 1'b1;
   logic        hw_reset_n = 1'b1;
   logic [2:0]  fault_pins = 3'h0;
   logic        sclk, sync_n, serial_data_in, serial_data_out, out_clamp, buf_pd, fault_n;
   logic [15:0] dac_code;
   dsu_state_t  upd_state;
   logic [23:0] rx;
   int          num_errors = 0;
   int          check_count = 0;

   always #2.5 clk_sys = ~clk_sys;

   dsu_host_model dsu_host_model_i (.i_sdo(serial_data_out), .o_sclk(sclk), .o_sync_n(sync_n), .o_sdi(serial_data_in));
   dsu_update_ctrl dsu_update_ctrl_i (.i_clk_sys(clk_sys), .i_rst(rst), .i_ce(ce), .i_sclk(sclk),
      .i_sync_n(sync_n), .i_serial_data_in(serial_data_in), .i_load_strobe_n(load_n), .i_clear_n(clear_n),
      .i_hw_reset_n(hw_reset_n), .i_overtemp(fault_pins[0]), .i_short_circuit(fault_pins[1]),
      .i_brownout(fault_pins[2]), .o_serial_data_out(serial_data_out), .o_dac_code(dac_code),
      .o_out_clamp(out_clamp), .o_buf_powerdown(buf_pd), .o_fault_n(fault_n), .o_update_state(upd_state));

   task automatic fail(input string msg);
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask
   task automatic chk_code(input logic [15:0] got, input logic [15:0] exp, input string msg);
      check_count++;
      if (got !== exp) fail(msg);
   endtask
   task automatic chk_flag(input logic got, input logic exp, input string msg);
      check_count++;
      if (got !== exp) fail(msg);
   endtask
   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string msg);
      check_count++;
      if (got !== exp) fail(msg);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic frame(input logic [3:0] cmd, input logic [15:0] data);
      dsu_host_model_i.xfer({4'h0, cmd, data}, rx);
      cyc(6);
   endtask

   task automatic test_reset;
      chk_code(dac_code, `DSU_DAC_RST, "dac after reset");
      chk_flag(out_clamp & buf_pd, 1'b1, "clamp after reset");
      chk_flag(fault_n, 1'b0, "fault after reset");
      chk_code(16'(upd_state), 16'(DSU_ST_IDLE), "state after reset");
      $display("test_reset done");
   endtask
   task automatic test_direct;
      frame(`DSU_CMD_WR_CTRL, 16'h0004);
      chk_flag(fault_n, 1'b1, "fault after ctrl write");
      chk_flag(out_clamp | buf_pd, 1'b0, "output enable");
      frame(`DSU_CMD_WR_INPUT, 16'h1234);
      chk_code(dac_code, 16'h1234, "direct update");
      frame(`DSU_CMD_RD_INPUT, 16'h0000);
      frame(`DSU_CMD_NOP, 16'hC3A5);
      chk_word(rx, {4'h0, `DSU_CMD_RD_INPUT, 16'h1234}, "readback");
      frame(`DSU_CMD_NOP, 16'h0000);
      chk_word(rx, {4'h0, `DSU_CMD_NOP, 16'hC3A5}, "daisy chain");
      $display("test_direct done");
   endtask
   task automatic test_defer;
      @(posedge clk_sys) load_n <= 1'b1;
      cyc(4);
      frame(`DSU_CMD_WR_INPUT, 16'hBEEF);
      chk_code(dac_code, 16'h1234, "deferred dac held");
      chk_code(16'(upd_state), 16'(DSU_ST_DEFER), "deferred state");
      @(posedge clk_sys) load_n <= 1'b0;
      cyc(6);
      chk_code(dac_code, 16'hBEEF, "load fall update");
      chk_code(16'(upd_state), 16'(DSU_ST_IDLE), "state after load");
      $display("test_defer done");
   endtask
   task automatic test_clear;
      logic [15:0] exp [4];
      exp = '{`DSU_CODE_ZERO, `DSU_CODE_MID, `DSU_CODE_FULL, `DSU_CODE_ZERO};
      for (int i = 0; i < 4; i++) begin
         frame(`DSU_CMD_WR_CTRL, {13'h0000, 1'b1, 2'(i)});
         @(posedge clk_sys) clear_n <= 1'b0;
         cyc(6);
         chk_code(dac_code, exp[i], "clear preset");
         @(posedge clk_sys) clear_n <= 1'b1;
         cyc(4);
      end
      $display("test_clear done");
   endtask
   task automatic test_idle_clocks;
      dsu_host_model_i.idle_clocks(8);
      frame(`DSU_CMD_NOP, 16'h0000);
      chk_word(rx, {4'h0, `DSU_CMD_WR_CTRL, 16'h0007}, "shift kept between frames");
      $display("test_idle_clocks done");
   endtask
   task automatic test_faults;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys) fault_pins <= 3'h1 << i;
         cyc(5);
         chk_flag(fault_n, 1'b0, "fault raised");
         @(posedge clk_sys) fault_pins <= 3'h0;
         cyc(5);
         chk_flag(fault_n, 1'b1, "fault gone");
      end
      @(posedge clk_sys) ce <= 1'b0;
      fault_pins <= 3'h4;
      cyc(6);
      chk_flag(fault_n, 1'b1, "flag frozen by enable");
      @(posedge clk_sys) ce <= 1'b1;
      cyc(6);
      chk_flag(fault_n, 1'b0, "fault after enable");
      @(posedge clk_sys) fault_pins <= 3'h0;
      cyc(5);
      chk_flag(fault_n, 1'b1, "fault gone after enable");
      $display("test_faults done");
   endtask
   task automatic test_hw_reset;
      @(posedge clk_sys) hw_reset_n <= 1'b0;
      cyc(6);
      chk_code(dac_code, `DSU_DAC_RST, "dac on hw reset");
      chk_flag(out_clamp & buf_pd, 1'b1, "clamp on hw reset");
      chk_flag(fault_n, 1'b0, "fault on hw reset");
      @(posedge clk_sys) hw_reset_n <= 1'b1;
      cyc(4);
      frame(`DSU_CMD_WR_CTRL, 16'h0004);
      chk_flag(fault_n, 1'b1, "fault release");
      $display("test_hw_reset done");
   endtask
   task automatic test_cmds;
      @(posedge clk_sys) load_n <= 1'b1;
      cyc(4);
      frame(`DSU_CMD_WR_INPUT, 16'h5A5A);
      chk_code(dac_code, `DSU_DAC_RST, "write held by load");
      frame(`DSU_CMD_UPD_DAC, 16'h0000);
      chk_code(dac_code, 16'h5A5A, "update command");
      chk_code(16'(upd_state), 16'(DSU_ST_IDLE), "state after update");
      frame(`DSU_CMD_RD_DAC, 16'h0000);
      frame(`DSU_CMD_RD_CTRL, 16'h0000);
      chk_word(rx, {4'h0, `DSU_CMD_RD_DAC, 16'h5A5A}, "converter readback");
      frame(`DSU_CMD_SW_RESET, 16'h0000);
      chk_word(rx, {4'h0, `DSU_CMD_RD_CTRL, 16'h0004}, "control readback");
      chk_code(dac_code, `DSU_DAC_RST, "dac after soft reset");
      chk_flag(out_clamp & buf_pd, 1'b1, "clamp after soft reset");
      chk_flag(fault_n, 1'b0, "fault after soft reset");
      @(posedge clk_sys) load_n <= 1'b0;
      cyc(6);
      chk_code(dac_code, `DSU_INPUT_RST, "load after soft reset");
      $display("test_cmds done");
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // about 17 frames of 1.2 us each, so 300 us is ample
   initial begin
      #300us;
      fail("watchdog");
      test_done();
   end
   initial begin
      cyc(16);
      rst <= 1'b0;
      cyc(4);
      test_reset();
      test_direct();
      test_defer();
      test_clear();
      test_idle_clocks();
      test_faults();
      test_hw_reset();
      test_cmds();
      test_done();
   end
endmodule
